// ---- bench/oscillator_clock_control_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("wrong value %s exp %h got %h", n, e, g); end end
module oscillator_clock_control_tb_top;
  import clock_ctl_pkg::*;
  logic mclk = 0, nrst = 0, hsel = 0, hwrite = 0, irq_event = 0, failsafe_config_bit = 0, clock_fail_pin = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdq;
  logic [1:0] htrans = 0;
  logic [2:0] config_source = 3'h2, active_source_sel;
  logic hreadyout, hresp, pin_config_lock, osc_fail_trap, cpu_clk_en, fast_rc_div_en, loop_enable;
  logic aux_loop_enable, aux_loop_input, pwm_fine_resolution, ref_clk_out;
  logic [5:0] loop_input_ratio;
  logic [3:0] loop_output_ratio;
  logic [9:0] loop_feedback_mult;
  int mismatches = 0, cmp_count = 0, traps = 0, k;
  logic [7:0] ra [8] = '{8'h08, 8'h08, 8'h04, 8'h04, 8'h04, 8'h10, 8'h40, 8'h0C};
  logic [31:0] rw [8] = '{32'h0, 32'h1FF, 32'hC0, 32'h80, 32'h7DF, 32'h27, 32'h1234, 32'h55};
  logic [31:0] rx [8] = '{32'h0, 32'h1FF, 32'hC0, 32'hC0, 32'h7DF, 32'h1027, 32'h0, 32'h0};
  initial forever #2 mclk = ~mclk;
  always @(negedge mclk) if (osc_fail_trap === 1'b1) traps++;
  oscillator_clock_control #(.SWITCH_CYCLES(2), .LOOP_STARTUP_CYCLES(8)) dut (
    .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .config_source(config_source), .failsafe_config_bit(failsafe_config_bit),
    .irq_event(irq_event), .clock_fail_pin(clock_fail_pin), .loop_lock_pin(1'b1), .crystal_pin(1'b0),
    .active_source_sel(active_source_sel), .loop_enable(loop_enable), .pin_config_lock(pin_config_lock),
    .osc_fail_trap(osc_fail_trap), .cpu_clk_en(cpu_clk_en), .fast_rc_div_en(fast_rc_div_en),
    .loop_input_ratio(loop_input_ratio), .loop_output_ratio(loop_output_ratio),
    .loop_feedback_mult(loop_feedback_mult), .aux_loop_enable(aux_loop_enable), .aux_loop_input(aux_loop_input),
    .pwm_fine_resolution(pwm_fine_resolution), .ref_clk_out(ref_clk_out));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Sampling at the falling edge keeps the value stable through the next rising edge.
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin @(negedge mclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin mismatches++; complete_run(); end
    rdq = hrdata;
    @(posedge mclk);
  endtask : wait_rdy
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy();
  endtask : xf
  task automatic ul(input logic [31:0] d);
    xf(1, 8'h0C, 32'h55);
    xf(1, 8'h0C, 32'hAA);
    xf(1, 8'h00, d);
  endtask : ul
  task automatic osc_rd(input string nm, input logic [31:0] e);
    repeat (20) begin xf(0, 8'h00, 0); if (rdq[0] === 1'b0) break; end
    `CHK(nm, e, rdq & 32'hFFDF)
  endtask : osc_rd
  // Selector 0 counts processor enables, 1 fast RC enables, 2 rising edges of the reference pin.
  task automatic cnt(input int s, input int cyc);
    logic p;
    k = 0;
    @(negedge mclk);
    p = ref_clk_out;
    repeat (cyc) begin
      @(negedge mclk);
      k += (s == 2) ? int'(ref_clk_out === 1'b1 && p === 1'b0) :
           (s == 1) ? int'(fast_rc_div_en === 1'b1) : int'(cpu_clk_en === 1'b1);
      p = ref_clk_out;
    end
    @(posedge mclk);
  endtask : cnt
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    osc_rd("osc reset", 32'h2200);
    xf(0, 8'h04, 0); `CHK("div reset", 32'h3040, rdq)
    xf(0, 8'h08, 0); `CHK("fbd reset", 32'h30, rdq)
    `CHK("mult reset", 10'd50, loop_feedback_mult)
    for (int i = 0; i < 8; i++) begin
      xf(1, ra[i], rw[i]);
      xf(0, ra[i], 0);
      `CHK("row readback", rx[i], rdq)
    end
    `CHK("aux loop", 1'b1, aux_loop_enable)
    `CHK("aux input", 1'b1, aux_loop_input)
    `CHK("fine pwm", 1'b1, pwm_fine_resolution)
    cnt(2, 64); `CHK("ref rises", 16, k)
    `CHK("input ratio", 6'd33, loop_input_ratio)
    `CHK("output ratio", 4'd8, loop_output_ratio)
    `CHK("feedback mult", 10'd513, loop_feedback_mult)
    cnt(1, 1024); `CHK("frc pulses", 4, k)
    $display("test dividers done");
    xf(1, 8'h04, 32'h800); xf(0, 8'h04, 0); `CHK("enable at 000", 32'h0, rdq)
    xf(1, 8'h04, 32'hA800); xf(0, 8'h04, 0); `CHK("enable", 32'hA800, rdq)
    cnt(0, 64); `CHK("cpu pulses div4", 16, k)
    xf(1, 8'h04, 32'hD800); xf(0, 8'h04, 0); `CHK("field locked", 32'hA800, rdq)
    irq_event <= 1'b1; @(posedge mclk); irq_event <= 1'b0; @(posedge mclk);
    xf(0, 8'h04, 0); `CHK("irq recover", 32'hA000, rdq)
    cnt(0, 64); `CHK("cpu pulses 1:1", 64, k)
    $display("test reduction done");
    xf(1, 8'h00, 32'h1); osc_rd("no unlock", 32'h2200);
    `CHK("hresp", 1'b0, hresp)
    ul(32'h1); osc_rd("switch", 32'h0);
    `CHK("active port", 3'h0, active_source_sel)
    ul(32'h101); osc_rd("loop switch", 32'h1100);
    `CHK("loop lock bit", 1'b1, rdq[5])
    `CHK("loop enable", 1'b1, loop_enable)
    ul(32'h401); osc_rd("reserved", 32'h1400);
    ul(32'h408); osc_rd("flag set", 32'h1408);
    `CHK("trap", 1, traps)
    failsafe_config_bit <= 1'b1;
    ul(32'h80); osc_rd("lock", 32'h1080);
    ul(32'h201); osc_rd("locked", 32'h1080);
    ul(32'hC0); osc_rd("pin lock", 32'h10C0);
    `CHK("pin port", 1'b1, pin_config_lock)
    clock_fail_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    clock_fail_pin <= 1'b0;
    osc_rd("monitor fail", 32'h10C8);
    `CHK("monitor trap", 2, traps)
    $display("test control done");
    config_source <= 3'h5;
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    osc_rd("reset again", 32'h5500);
    `CHK("pin port reset", 1'b0, pin_config_lock)
    $display("test reset done");
    complete_run();
  end
endmodule : oscillator_clock_control_tb_top

// ---- logic/clock_ctl_defines.svh ----
`ifndef CLOCK_CTL_DEFINES_SVH
`define CLOCK_CTL_DEFINES_SVH

// Byte offsets of the registers on the bus.
`define OFS_OSC_CTL 8'h00
`define OFS_CLK_DIV 8'h04
`define OFS_LOOP_FBD 8'h08
`define OFS_UNLOCK 8'h0C
`define OFS_AUX_CTL 8'h10

// Two-step key that arms exactly one write to the oscillator control register.
`define UNLOCK_KEY1 16'h0055
`define UNLOCK_KEY2 16'h00AA

// Reset values.
`define RST_REDUCTION 3'h3
`define RST_FRC_POST 3'h0
`define RST_LOOP_POST 2'h1
`define RST_LOOP_PRE 5'h00
`define RST_LOOP_FBD 9'h030

// Field codes and biases.
`define LOOP_POST_RSVD 2'h2
`define LOOP_POST_DIV2 2'h0
`define LOOP_POST_DIV4 2'h1
`define LOOP_POST_DIV8 2'h3
`define FRC_POST_MAX 3'h7
`define FRC_TERM_256 8'hFF
`define REDUCTION_NONE 3'h0
`define PRE_BIAS 6'h02
`define FBD_BIAS 10'h002
`define AUX_LOOP_MULT 5'h10
`define RATIO_DIV2 4'h2
`define RATIO_DIV4 4'h4
`define RATIO_DIV8 4'h8
`define RATIO_NONE 4'h0

// Bus encodings.
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'b0

`endif

// ---- logic/clock_ctl_pkg.sv ----
package clock_ctl_pkg;

  typedef enum logic [2:0] {
    SRC_FRC = 3'h0, SRC_FRC_LOOP = 3'h1, SRC_PRI = 3'h2, SRC_PRI_LOOP = 3'h3,
    SRC_RSVD = 3'h4, SRC_LOW_POWER_RC_OSCILLATOR = 3'h5, SRC_FRC_DIV16 = 3'h6, SRC_FRC_DIVN = 3'h7
  } source_sel_t;

  typedef enum logic [1:0] {SW_IDLE = 2'b00, SW_SETTLE = 2'b01, SW_LOCK_WAIT = 2'b10} switch_state_t;

  typedef enum logic [1:0] {UL_LOCKED = 2'b00, UL_HALF = 2'b01, UL_ARMED = 2'b10} unlock_state_t;

  typedef struct packed {
    logic rsv15;
    source_sel_t active_source_sel;
    logic rsv11;
    source_sel_t requested_source_sel;
    logic clock_config_lock;
    logic pin_config_lock;
    logic loop_locked;
    logic rsv4;
    logic clock_fail_flag;
    logic [1:0] rsv2;
    logic switch_request;
  } osc_ctl_t;

  typedef struct packed {
    logic recover_on_irq;
    logic [2:0] reduction;
    logic reduction_enable;
    logic [2:0] fast_rc_postscaler;
    logic [1:0] loop_output_divider;
    logic rsv5;
    logic [4:0] loop_input_divider;
  } clk_div_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic [4:0] aux_mult;
    logic [3:0] ref_div;
    logic ref_src_crystal;
    logic ref_enable;
    logic aux_input_frc;
    logic aux_enable;
  } aux_ctl_t;

endpackage : clock_ctl_pkg

// ---- logic/oscillator_clock_control.sv ----
`timescale 1ns/1ps
`include "clock_ctl_defines.svh"
// What this block does
// - Auxiliary clock comes from a fixed sixteen-times loop fed by primary or fast RC.
// - Fine PWM resolution only with the auxiliary loop; otherwise 8 ns at best.
// - Read-only bits 14-12 report the active clock source.
// - Bits 10-8 hold the requested source, loaded from configuration at power-on.
// - Writing one to bit 0 requests a switch; hardware clears it when done.
// - Lock bit 7 with fail-safe configuration set blocks clock and loop changes.
// - Bit 6 set activates the pin configuration lock; cleared releases it.
// - Bit 5 reads one when the loop is locked or its start-up timer expired.
// - Monitor sets clock-fail bit 3; software writing one raises a failure trap.
// - Oscillator control writes need an unlock sequence before each write.
// - With recover set, any interrupt clears reduction enable, ratio back to one.
// - Reduction field divides processor clock by two to its power; resets to 011.
// - Reduction field writes are ignored while reduction is enabled.
// - Setting reduction enable is ignored while the reduction field is 000.
// - Enabled, the field sets the clock ratio; disabled, the ratio is one.
// - Fast RC postscaler divides by 1 to 64, and 256 for code 111.
// - Loop output divider divides by 2, 4 or 8; code 10 is reserved.
// - Loop input divider divides by its value plus two, 2 to 33.
// - A reference clock pin carries scaled system or crystal clock.
// - Loop feedback divisor multiplies by value plus two; resets to fifty.
module oscillator_clock_control
  import clock_ctl_pkg::*;
#(
  parameter int unsigned SWITCH_CYCLES = 16,
  parameter int unsigned LOOP_STARTUP_CYCLES = 1024
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Configuration and system events.
  input wire logic [2:0] config_source,
  input wire logic failsafe_config_bit,
  input wire logic irq_event,
  // Asynchronous pins from the analog side.
  input wire logic clock_fail_pin,
  input wire logic loop_lock_pin,
  input wire logic crystal_pin,
  // Clock control outputs.
  output logic [2:0] active_source_sel,
  output logic loop_enable,
  output logic pin_config_lock,
  output logic osc_fail_trap,
  output logic cpu_clk_en,
  output logic fast_rc_div_en,
  output logic [5:0] loop_input_ratio,
  output logic [3:0] loop_output_ratio,
  output logic [9:0] loop_feedback_mult,
  output logic aux_loop_enable,
  output logic aux_loop_input,
  output logic pwm_fine_resolution,
  output logic ref_clk_out
);

  localparam int unsigned SWW = $clog2(SWITCH_CYCLES + 1);
  localparam int unsigned STW = $clog2(LOOP_STARTUP_CYCLES + 1);

  osc_ctl_t osc;
  clk_div_t div;
  aux_ctl_t aux;
  logic [8:0] fbd;
  unlock_state_t ul;
  switch_state_t st;
  logic [SWW-1:0] sw_cnt;
  logic [STW-1:0] start_cnt;
  logic cfg_loaded;

  // Bus pipeline.
  logic addr_phase;
  logic dp_write;
  logic rd_wait;
  logic [7:0] dp_addr;
  logic [15:0] wd;
  logic [15:0] read_image;
  osc_ctl_t wosc;
  clk_div_t wdiv;

  assign addr_phase = hsel & htrans[`HTRANS_ACTIVE_BIT] & hready;
  assign wd = hwdata[15:0];
  assign wosc = osc_ctl_t'(wd);
  assign wdiv = clk_div_t'(wd);

  // Writes finish with no wait state; reads take one so that the data flop sees a write just before.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dp_write <= 1'b0;
      rd_wait <= 1'b0;
      dp_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
    end else begin
      dp_write <= addr_phase & hwrite;
      rd_wait <= addr_phase & ~hwrite;
      hreadyout <= ~(addr_phase & ~hwrite);
      if (addr_phase) begin
        dp_addr <= haddr[7:0];
      end
    end
  end

  always_comb begin
    unique case (dp_addr)
      `OFS_OSC_CTL: read_image = osc;
      `OFS_CLK_DIV: read_image = div;
      `OFS_LOOP_FBD: read_image = {7'h00, fbd};
      `OFS_AUX_CTL: read_image = aux;
      default: read_image = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait) begin
      hrdata <= {16'h0000, read_image};
    end
  end

  logic wr_osc;
  logic wr_div;
  logic wr_fbd;
  logic wr_aux;
  logic wr_key;
  logic osc_write;
  logic cfg_locked;

  assign wr_osc = dp_write && (dp_addr == `OFS_OSC_CTL);
  assign wr_div = dp_write && (dp_addr == `OFS_CLK_DIV);
  assign wr_fbd = dp_write && (dp_addr == `OFS_LOOP_FBD);
  assign wr_aux = dp_write && (dp_addr == `OFS_AUX_CTL);
  assign wr_key = dp_write && (dp_addr == `OFS_UNLOCK);
  assign osc_write = wr_osc && (ul == UL_ARMED);
  assign cfg_locked = osc.clock_config_lock & failsafe_config_bit;

  // Any other write to the key register, or any oscillator control write, disarms the sequence.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ul <= UL_LOCKED;
    end else if (wr_key) begin
      if (wd == `UNLOCK_KEY1) begin
        ul <= UL_HALF;
      end else if (wd == `UNLOCK_KEY2 && ul == UL_HALF) begin
        ul <= UL_ARMED;
      end else begin
        ul <= UL_LOCKED;
      end
    end else if (wr_osc) begin
      ul <= UL_LOCKED;
    end
  end

  // Three-stage synchronisers; a change counts once stages two and three agree.
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_stable;
  logic [2:0] pin_prev;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
      pin_stable <= 3'h0;
      pin_prev <= 3'h0;
    end else begin
      sync1 <= {crystal_pin, loop_lock_pin, clock_fail_pin};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_stable <= (sync3 & ~(sync2 ^ sync3)) | (pin_stable & (sync2 ^ sync3));
      pin_prev <= pin_stable;
    end
  end

  logic fail_evt;
  logic xtal_rise;
  logic sw_fail_set;
  assign fail_evt = pin_stable[0] & ~pin_prev[0];
  assign xtal_rise = pin_stable[2] & ~pin_prev[2];
  assign sw_fail_set = osc_write && wosc.clock_fail_flag;

  // Switch sequencing.
  logic loop_target;
  logic loop_lock_ok;
  logic switch_done;
  assign loop_target = (osc.requested_source_sel == SRC_FRC_LOOP) || (osc.requested_source_sel == SRC_PRI_LOOP);
  assign loop_lock_ok = loop_enable && (pin_stable[1] || start_cnt == '0);
  assign switch_done = ((st == SW_SETTLE) && (sw_cnt == '0) && !loop_target) ||
                       ((st == SW_LOCK_WAIT) && loop_lock_ok);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= SW_IDLE;
      sw_cnt <= '0;
    end else begin
      unique case (st)
        SW_IDLE: begin
          if (osc.switch_request && osc.requested_source_sel != SRC_RSVD) begin
            st <= SW_SETTLE;
            sw_cnt <= SWW'(SWITCH_CYCLES - 1);
          end
        end
        SW_SETTLE: begin
          if (sw_cnt == '0) begin
            st <= loop_target ? SW_LOCK_WAIT : SW_IDLE;
          end else begin
            sw_cnt <= sw_cnt - SWW'(1);
          end
        end
        SW_LOCK_WAIT: begin
          if (loop_lock_ok) begin
            st <= SW_IDLE;
          end
        end
        default: st <= SW_IDLE;
      endcase
    end
  end

  // The loop powers up ahead of a switch into a loop source, so the lock wait can end.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      loop_enable <= 1'b0;
      start_cnt <= STW'(LOOP_STARTUP_CYCLES);
    end else begin
      loop_enable <= (osc.active_source_sel == SRC_FRC_LOOP) || (osc.active_source_sel == SRC_PRI_LOOP) ||
                     ((st != SW_IDLE) && loop_target);
      if (!loop_enable) begin
        start_cnt <= STW'(LOOP_STARTUP_CYCLES);
      end else if (start_cnt != '0) begin
        start_cnt <= start_cnt - STW'(1);
      end
    end
  end

  // Source selection. The strap level is caught on the first edge after reset release.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_loaded <= 1'b0;
      osc.rsv15 <= 1'b0;
      osc.active_source_sel <= SRC_FRC;
      osc.rsv11 <= 1'b0;
      osc.requested_source_sel <= SRC_FRC;
      osc.switch_request <= 1'b0;
      osc.loop_locked <= 1'b0;
      osc.rsv4 <= 1'b0;
      osc.rsv2 <= 2'h0;
    end else begin
      osc.loop_locked <= loop_lock_ok;
      if (!cfg_loaded) begin
        cfg_loaded <= 1'b1;
        osc.active_source_sel <= source_sel_t'(config_source);
        osc.requested_source_sel <= source_sel_t'(config_source);
      end else if (switch_done) begin
        osc.active_source_sel <= osc.requested_source_sel;
        osc.switch_request <= 1'b0;
      end else if (st == SW_IDLE && osc.switch_request && osc.requested_source_sel == SRC_RSVD) begin
        osc.switch_request <= 1'b0;
      end else if (osc_write && !cfg_locked && !osc.switch_request) begin
        // The target is held steady while a switch is in flight.
        osc.requested_source_sel <= wosc.requested_source_sel;
        osc.switch_request <= wosc.switch_request;
      end
    end
  end

  // Locks. While locked with fail-safe configuration set, the clock lock itself cannot be released until reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      osc.clock_config_lock <= 1'b0;
      osc.pin_config_lock <= 1'b0;
      pin_config_lock <= 1'b0;
    end else begin
      pin_config_lock <= osc.pin_config_lock;
      if (osc_write) begin
        osc.pin_config_lock <= wosc.pin_config_lock;
        if (!cfg_locked) begin
          osc.clock_config_lock <= wosc.clock_config_lock;
        end
      end
    end
  end

  // A failure in the same cycle as a software clear keeps the flag set.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      osc.clock_fail_flag <= 1'b0;
      osc_fail_trap <= 1'b0;
    end else begin
      osc_fail_trap <= fail_evt | sw_fail_set;
      if (fail_evt || sw_fail_set) begin
        osc.clock_fail_flag <= 1'b1;
      end else if (osc_write) begin
        osc.clock_fail_flag <= 1'b0;
      end
    end
  end

  // Clock divisor register.
  logic [2:0] next_reduction;
  assign next_reduction = div.reduction_enable ? div.reduction : wdiv.reduction;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div.recover_on_irq <= 1'b0;
      div.reduction <= `RST_REDUCTION;
      div.reduction_enable <= 1'b0;
      div.fast_rc_postscaler <= `RST_FRC_POST;
      div.loop_output_divider <= `RST_LOOP_POST;
      div.rsv5 <= 1'b0;
      div.loop_input_divider <= `RST_LOOP_PRE;
    end else begin
      if (wr_div) begin
        div.recover_on_irq <= wdiv.recover_on_irq;
        div.reduction <= next_reduction;
        div.reduction_enable <= wdiv.reduction_enable && (next_reduction != `REDUCTION_NONE);
        if (!cfg_locked) begin
          div.fast_rc_postscaler <= wdiv.fast_rc_postscaler;
          div.loop_input_divider <= wdiv.loop_input_divider;
          if (wdiv.loop_output_divider != `LOOP_POST_RSVD) begin
            div.loop_output_divider <= wdiv.loop_output_divider;
          end
        end
      end
      // An interrupt outranks a software write in the same cycle.
      if (irq_event && div.recover_on_irq) begin
        div.reduction_enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fbd <= `RST_LOOP_FBD;
    end else if (wr_fbd && !cfg_locked) begin
      fbd <= wd[8:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aux <= '0;
      aux.aux_mult <= `AUX_LOOP_MULT;
    end else if (wr_aux) begin
      aux.ref_div <= wd[7:4];
      aux.ref_src_crystal <= wd[3];
      aux.ref_enable <= wd[2];
      aux.aux_input_frc <= wd[1];
      aux.aux_enable <= wd[0];
    end
  end

  // Divider ratios handed to the analog loop and auxiliary path.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      loop_input_ratio <= `PRE_BIAS;
      loop_output_ratio <= `RATIO_DIV4;
      loop_feedback_mult <= `FBD_BIAS;
      aux_loop_enable <= 1'b0;
      aux_loop_input <= 1'b0;
      pwm_fine_resolution <= 1'b0;
      active_source_sel <= SRC_FRC;
    end else begin
      loop_input_ratio <= {1'b0, div.loop_input_divider} + `PRE_BIAS;
      unique case (div.loop_output_divider)
        `LOOP_POST_DIV2: loop_output_ratio <= `RATIO_DIV2;
        `LOOP_POST_DIV4: loop_output_ratio <= `RATIO_DIV4;
        `LOOP_POST_DIV8: loop_output_ratio <= `RATIO_DIV8;
        default: loop_output_ratio <= `RATIO_NONE;
      endcase
      loop_feedback_mult <= {1'b0, fbd} + `FBD_BIAS;
      aux_loop_enable <= aux.aux_enable;
      aux_loop_input <= aux.aux_input_frc;
      pwm_fine_resolution <= aux.aux_enable;
      active_source_sel <= osc.active_source_sel;
    end
  end

  // Processor clock enable; a disabled reduction reloads at once so recovery is immediate.
  logic [6:0] doze_cnt;
  logic [6:0] doze_term;
  assign doze_term = div.reduction_enable ? 7'((8'h01 << div.reduction) - 8'h01) : 7'h00;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      doze_cnt <= 7'h00;
      cpu_clk_en <= 1'b0;
    end else begin
      cpu_clk_en <= (doze_cnt == 7'h00);
      if (!div.reduction_enable || doze_cnt == 7'h00) begin
        doze_cnt <= doze_term;
      end else begin
        doze_cnt <= doze_cnt - 7'h01;
      end
    end
  end

  logic [7:0] frc_cnt;
  logic [7:0] frc_term;
  assign frc_term = (div.fast_rc_postscaler == `FRC_POST_MAX) ? `FRC_TERM_256 :
                    8'((9'h001 << div.fast_rc_postscaler) - 9'h001);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frc_cnt <= 8'h00;
      fast_rc_div_en <= 1'b0;
    end else begin
      fast_rc_div_en <= (frc_cnt == 8'h00);
      frc_cnt <= (frc_cnt == 8'h00) ? frc_term : frc_cnt - 8'h01;
    end
  end

  // Reference output. The system source can at best be halved, since the pin is a flop at mclk.
  logic [14:0] ref_cnt;
  logic [14:0] ref_half_m1;
  logic ref_tick;
  assign ref_tick = aux.ref_src_crystal ? xtal_rise : 1'b1;
  assign ref_half_m1 = (aux.ref_div == 4'h0) ? 15'h0000 : (15'h0001 << (aux.ref_div - 4'h1)) - 15'h0001;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ref_cnt <= 15'h0000;
      ref_clk_out <= 1'b0;
    end else if (!aux.ref_enable) begin
      ref_cnt <= 15'h0000;
      ref_clk_out <= 1'b0;
    end else if (aux.ref_src_crystal && aux.ref_div == 4'h0) begin
      ref_clk_out <= pin_stable[2];
    end else if (ref_tick) begin
      if (ref_cnt >= ref_half_m1) begin
        ref_cnt <= 15'h0000;
        ref_clk_out <= ~ref_clk_out;
      end else begin
        ref_cnt <= ref_cnt + 15'h0001;
      end
    end
  end

  property p_reserved_drop;
    @(posedge mclk) disable iff (!nrst)
      (cfg_loaded && st == SW_IDLE && osc.switch_request && osc.requested_source_sel == SRC_RSVD)
      |=> !osc.switch_request && $stable(osc.active_source_sel);
  endproperty
  a_reserved_drop: assert property (p_reserved_drop) else $error("reserved switch not dropped");

  property p_switch_done;
    @(posedge mclk) disable iff (!nrst)
      (cfg_loaded && switch_done) |=> !osc.switch_request && osc.active_source_sel == $past(osc.requested_source_sel);
  endproperty
  a_switch_done: assert property (p_switch_done) else $error("switch did not complete");

  property p_lock_blocks;
    @(posedge mclk) disable iff (!nrst)
      (cfg_loaded && osc_write && cfg_locked) |=> $stable(osc.requested_source_sel) && $stable(fbd);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked config changed");

  property p_unlock_needed;
    @(posedge mclk) disable iff (!nrst)
      (wr_osc && ul != UL_ARMED) |=> $stable(osc.pin_config_lock) ##1 $stable(pin_config_lock);
  endproperty
  a_unlock_needed: assert property (p_unlock_needed) else $error("write without unlock took effect");

  property p_reduction_frozen;
    @(posedge mclk) disable iff (!nrst)
      (wr_div && div.reduction_enable) |=> $stable(div.reduction);
  endproperty
  a_reduction_frozen: assert property (p_reduction_frozen) else $error("reduction changed while enabled");

  property p_enable_refused;
    @(posedge mclk) disable iff (!nrst)
      (wr_div && !div.reduction_enable && wdiv.reduction == `REDUCTION_NONE) |=> !div.reduction_enable;
  endproperty
  a_enable_refused: assert property (p_enable_refused) else $error("enable set with zero field");

  property p_irq_recover;
    @(posedge mclk) disable iff (!nrst)
      (irq_event && div.recover_on_irq) |=> !div.reduction_enable;
  endproperty
  a_irq_recover: assert property (p_irq_recover) else $error("interrupt did not clear enable");

  property p_unity_ratio;
    @(posedge mclk) disable iff (!nrst)
      (!div.reduction_enable)[*3] |-> cpu_clk_en;
  endproperty
  a_unity_ratio: assert property (p_unity_ratio) else $error("ratio not one while disabled");

  property p_fail_trap;
    @(posedge mclk) disable iff (!nrst)
      (fail_evt || sw_fail_set) |=> osc.clock_fail_flag && osc_fail_trap;
  endproperty
  a_fail_trap: assert property (p_fail_trap) else $error("failure not flagged");

  property p_loop_status;
    @(posedge mclk) disable iff (!nrst)
      !loop_enable |=> !osc.loop_locked;
  endproperty
  a_loop_status: assert property (p_loop_status) else $error("lock shown with loop off");

  property p_feedback;
    @(posedge mclk) disable iff (!nrst)
      (cfg_loaded && $stable(fbd)) |=> loop_feedback_mult == {1'b0, $past(fbd)} + `FBD_BIAS;
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback multiplier wrong");

endmodule : oscillator_clock_control
